// *** mdms_assertions.sv ***
// checker for the mode sequencer outputs and its apb answer
// assumes binding to mdms_sequencer; only its ports are seen
`timescale 1ns/10ps
module mdms_checker #(
   parameter STANDBY_REQUEST_PIN_CYC = 50
) (
   input wire clock,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire standby_request_pin,
   input wire [2:0] mode_out,
   input wire drive_enable,
   input wire short_brake,
   input wire fets_hiz
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   reg [31:0] low_ff;
   // raw pin is counted, so the sync delay only adds margin
   wire [31:0] nxt_low = standby_request_pin ? 32'h00000000 : low_ff + 32'h00000001;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         low_ff <= 32'h00000000;
      else
         low_ff <= nxt_low;
   end
   sequence s_load_done;
      mode_out == 3'h0 ##1 mode_out != 3'h0;
   endsequence
   sequence s_standby_request_pin_entry;
      mode_out != 3'h6 ##1 mode_out == 3'h6;
   endsequence
   a_load_then_brake: assert property (s_load_done |-> mode_out == 3'h1)
      else $error("load not followed by brake");
   a_run_drives: assert property (mode_out inside {3, 4} |-> drive_enable && !fets_hiz)
      else $error("startup or run without drive");
   a_idle_fets_off: assert property (mode_out == 3'h2 |-> fets_hiz && !drive_enable)
      else $error("idle with fets on");
   a_standby_off: assert property (mode_out == 3'h6 |-> fets_hiz && !short_brake)
      else $error("standby with fets on");
   a_brake_only: assert property (short_brake |-> mode_out == 3'h1 && !fets_hiz)
      else $error("short brake outside brake");
   a_error_cause: assert property ($changed(mode_out) && mode_out == 3'h5
      |-> $past(mode_out) inside {3, 4})
      else $error("error mode entered from rest");
   a_standby_hold: assert property (s_standby_request_pin_entry |-> low_ff >= STANDBY_REQUEST_PIN_CYC)
      else $error("standby entered too early");
   a_brake_exit: assert property ($past(mode_out) == 3'h1 && mode_out != 3'h1
      |-> mode_out inside {2, 3, 6})
      else $error("bad exit from brake");
   a_apb_one_wait: assert property (pready |-> psel && penable && !$past(pready))
      else $error("pready outside access phase");
   a_slverr_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
endmodule
bind mdms_sequencer mdms_checker #(.STANDBY_REQUEST_PIN_CYC(STANDBY_REQUEST_PIN_CYC)) u_chk (.clock(clock), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .standby_request_pin(standby_request_pin), .mode_out(mode_out),
   .drive_enable(drive_enable), .short_brake(short_brake), .fets_hiz(fets_hiz));

// *** mdms_bridge_model.sv ***
// behavioural model of the external six-fet bridge and its current sense
// assumes the sequencer's fet controls; trip is commanded by the bench
`timescale 1ns/10ps
module mdms_bridge_model (
   input wire drive_enable,
   input wire short_brake,
   input wire fets_hiz,
   input wire trip,
   output wire fault_out,
   output wire [1:0] bridge_state
);
   // no current flows with all fets off, so an overload cannot show then
   assign fault_out = trip & ~fets_hiz;
   assign bridge_state = fets_hiz ? 2'h0 : (short_brake ? 2'h1 : {1'b1, drive_enable});
endmodule

// *** mdms_map.vh ***
// constants for the motor drive mode sequencer: register map, fields, resets, timing
// assumes byte addressing on a 32-bit apb bus, one word per register
`ifndef MDMS_MAP_VH
`define MDMS_MAP_VH
`define MDMS_ADDR_CTRL 12'h000
`define MDMS_ADDR_CFG 12'h004
`define MDMS_ADDR_RESTART 12'h008
`define MDMS_ADDR_STATUS 12'h00c
`define MDMS_ADDR_IRQ_STAT 12'h010
`define MDMS_ADDR_IRQ_MASK 12'h014
// cfg fields
`define MDMS_CFG_BRAKE_LO 0
`define MDMS_CFG_BRAKE_HI 2
`define MDMS_CFG_BRAKE_STYLE 4
`define MDMS_CFG_BRAKE_HOLD 3
`define MDMS_CFG_STANDBY_REQUEST_PIN_SEL 7
`define MDMS_CFG_MAXOVR 8
`define MDMS_CFG_NO_STOP_SETTING 9
`define MDMS_CFG_SPEED_COMMAND_INVERSION 10
`define MDMS_CFG_RESET 11'h000
// ctrl fields
`define MDMS_CTRL_SPEED_LO 0
`define MDMS_CTRL_SPEED_HI 7
`define MDMS_CTRL_RESET 8'h00
`define MDMS_RESTART_RESET 16'h000a
// irq bits
`define MDMS_IRQ_ERROR 0
`define MDMS_IRQ_STANDBY 1
`define MDMS_IRQ_IDLE 2
`define MDMS_IRQ_START 3
// timing
`define MDMS_CLK_HZ 10000000
`define MDMS_STANDBY_REQUEST_PIN_MS 100
`define MDMS_STANDBY_REQUEST_PIN_CYC ((`MDMS_CLK_HZ / 1000) * `MDMS_STANDBY_REQUEST_PIN_MS)
`define MDMS_SEC_CYC `MDMS_CLK_HZ
`define MDMS_LOAD_CYC 16
`endif

// *** mdms_sequencer.v ***
// operating-mode sequencer of a sensorless bldc predriver, with apb registers
// assumes apb master on clock; fault, nvm image and standby pin are asynchronous inputs
//
// Contract
// - after reset and no standby: load stored parameters, brake, then idle
// - nonzero speed command starts the motor via the startup sequence
// - any fault enters error mode; restart automatically after restart time (the code takes faults only in startup and run)
// - in error mode a stop command moves to idle
// - standby turns all outputs off (hi-z) and clears latched errors
// - select bit 0: standby whenever standby pin is low
// - select bit 1: standby only when pin low and speed command zero
// - select bit 1: no standby while override, no-stop or inversion set
// - standby condition must hold at least 100 ms before standby entry
// - brake period programmable 0 to 7 whole seconds
// - brake style 0 turns fets off, 1 applies short brake
// - brake hold 0 releases brake state after period and goes idle
// - brake hold 1 keeps brake until command, then startup; not for 0 s
// - command stop during run or error stop goes idle with fets off
// - from idle a speed command moves to startup
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "mdms_map.vh"
module mdms_sequencer #(
   parameter STANDBY_REQUEST_PIN_CYC = `MDMS_STANDBY_REQUEST_PIN_CYC,
   parameter SEC_CYC = `MDMS_SEC_CYC,
   parameter RESTART_UNIT = 10000
) (
   input wire clock,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [10:0] nvm_cfg,
   input wire standby_request_pin,
   input wire fault_in,
   output reg [2:0] mode_out,
   output reg drive_enable,
   output reg short_brake,
   output reg fets_hiz,
   output reg irq
);
   localparam ST_LOAD = 8'h01;
   localparam ST_BRAKE = 8'h02;
   localparam ST_HOLD = 8'h04;
   localparam ST_IDLE = 8'h08;
   localparam ST_START = 8'h10;
   localparam ST_RUN = 8'h20;
   localparam ST_ERROR = 8'h40;
   localparam ST_STANDBY_REQUEST_PIN = 8'h80;

   reg [7:0] state_ff, nxt_state;
   reg [31:0] cnt_ff, nxt_cnt;
   reg [31:0] standby_request_pin_cnt_ff;
   reg [10:0] cfg_ff;
   reg [7:0] ctrl_ff;
   reg [15:0] restart_ff;
   reg [3:0] irq_stat_ff, irq_mask_ff;
   reg [1:0] standby_request_pin_sync_ff, fault_sync_ff;
   reg [10:0] nvm_s1_ff, nvm_s2_ff;
   reg err_latch_ff;
   reg [3:0] ev;

   wire standby_request_pin_pin = standby_request_pin_sync_ff[1];
   wire fault = fault_sync_ff[1];
   wire speed_on = (ctrl_ff != 8'h00);
   wire [2:0] brake_sec = cfg_ff[`MDMS_CFG_BRAKE_HI:`MDMS_CFG_BRAKE_LO];
   wire sel1 = cfg_ff[`MDMS_CFG_STANDBY_REQUEST_PIN_SEL];
   wire blockers = cfg_ff[`MDMS_CFG_MAXOVR] | cfg_ff[`MDMS_CFG_NO_STOP_SETTING] |
      cfg_ff[`MDMS_CFG_SPEED_COMMAND_INVERSION];
   // standby condition as selected by the select bit
   wire standby_request_pin_cond = sel1 ? (!standby_request_pin_pin && !speed_on && !blockers) : !standby_request_pin_pin;
   wire standby_request_pin_ok = standby_request_pin_cnt_ff >= STANDBY_REQUEST_PIN_CYC;
   wire apb_wr = psel && penable && pwrite;
   wire apb_rd = psel && penable && !pwrite;
   wire apb_setup = psel && !penable;
   wire apb_hit = (paddr == `MDMS_ADDR_CTRL) || (paddr == `MDMS_ADDR_CFG) ||
      (paddr == `MDMS_ADDR_RESTART) || (paddr == `MDMS_ADDR_STATUS) ||
      (paddr == `MDMS_ADDR_IRQ_STAT) || (paddr == `MDMS_ADDR_IRQ_MASK);
   // read clear and new events settle here so irq drops with the clearing read
   wire rd_stat = apb_rd && pready && (paddr == `MDMS_ADDR_IRQ_STAT);
   wire [3:0] nxt_irq_stat = (rd_stat ? 4'h0 : irq_stat_ff) | ev;
   wire [31:0] brake_cyc = brake_sec * SEC_CYC;
   wire [31:0] restart_cyc = restart_ff * RESTART_UNIT;

   // pin inputs and the nvm image cross into the clock domain first
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         standby_request_pin_sync_ff <= 2'b11;
         fault_sync_ff <= 2'b00;
         nvm_s1_ff <= 11'h000;
         nvm_s2_ff <= 11'h000;
      end else begin
         standby_request_pin_sync_ff <= {standby_request_pin_sync_ff[0], standby_request_pin};
         fault_sync_ff <= {fault_sync_ff[0], fault_in};
         nvm_s1_ff <= nvm_cfg;
         nvm_s2_ff <= nvm_s1_ff;
      end
   end

   // qualification timer; a short dip restarts it so glitches never reach standby
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         standby_request_pin_cnt_ff <= 32'h00000000;
      end else if (!standby_request_pin_cond) begin
         standby_request_pin_cnt_ff <= 32'h00000000;
      end else if (!standby_request_pin_ok) begin
         standby_request_pin_cnt_ff <= standby_request_pin_cnt_ff + 32'h00000001;
      end
   end

   always @* begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      ev = 4'h0;
      case (state_ff)
         ST_LOAD: begin
            // the stored image is copied in while this state counts up
            if (cnt_ff >= `MDMS_LOAD_CYC) begin
               nxt_state = ST_BRAKE;
               nxt_cnt = 32'h00000000;
            end else begin
               nxt_cnt = cnt_ff + 32'h00000001;
            end
         end
         ST_BRAKE: begin
            if (cnt_ff >= brake_cyc) begin
               nxt_cnt = 32'h00000000;
               if (cfg_ff[`MDMS_CFG_BRAKE_HOLD] && brake_sec != 3'h0) begin
                  nxt_state = ST_HOLD;
               end else begin
                  nxt_state = ST_IDLE;
                  ev[`MDMS_IRQ_IDLE] = 1'b1;
               end
            end else begin
               nxt_cnt = cnt_ff + 32'h00000001;
            end
         end
         ST_HOLD: begin
            if (speed_on) begin
               nxt_state = ST_START;
               ev[`MDMS_IRQ_START] = 1'b1;
            end
         end
         ST_IDLE: begin
            if (speed_on) begin
               nxt_state = ST_START;
               ev[`MDMS_IRQ_START] = 1'b1;
            end
         end
         ST_START: begin
            // startup steps live elsewhere; a single cycle hands over to run
            if (!speed_on) begin
               nxt_state = ST_IDLE;
               ev[`MDMS_IRQ_IDLE] = 1'b1;
            end else begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!speed_on) begin
               nxt_state = ST_IDLE;
               ev[`MDMS_IRQ_IDLE] = 1'b1;
            end
         end
         ST_ERROR: begin
            if (!speed_on) begin
               nxt_state = ST_IDLE;
               nxt_cnt = 32'h00000000;
               ev[`MDMS_IRQ_IDLE] = 1'b1;
            end else if (cnt_ff >= restart_cyc && !fault) begin
               nxt_state = ST_START;
               nxt_cnt = 32'h00000000;
               ev[`MDMS_IRQ_START] = 1'b1;
            end else if (cnt_ff < restart_cyc) begin
               nxt_cnt = cnt_ff + 32'h00000001;
            end
         end
         ST_STANDBY_REQUEST_PIN: begin
            // wake goes back through the power-on path
            if (!standby_request_pin_cond) begin
               nxt_state = ST_LOAD;
               nxt_cnt = 32'h00000000;
            end
         end
         default: begin
            nxt_state = ST_LOAD;
            nxt_cnt = 32'h00000000;
         end
      endcase
      // faults in active modes override the normal flow
      if (fault && (state_ff == ST_START || state_ff == ST_RUN)) begin
         nxt_state = ST_ERROR;
         nxt_cnt = 32'h00000000;
         ev[`MDMS_IRQ_ERROR] = 1'b1;
      end
      // standby entry outranks everything; load waits for the pin before starting
      if (state_ff == ST_LOAD && standby_request_pin_cond) begin
         nxt_state = ST_LOAD;
         nxt_cnt = 32'h00000000;
      end else if (state_ff != ST_STANDBY_REQUEST_PIN && state_ff != ST_LOAD && standby_request_pin_cond && standby_request_pin_ok) begin
         nxt_state = ST_STANDBY_REQUEST_PIN;
         nxt_cnt = 32'h00000000;
         ev = 4'h0;
         ev[`MDMS_IRQ_STANDBY] = 1'b1;
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_LOAD;
         cnt_ff <= 32'h00000000;
         err_latch_ff <= 1'b0;
         mode_out <= 3'h0;
         drive_enable <= 1'b0;
         short_brake <= 1'b0;
         fets_hiz <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         if (nxt_state == ST_STANDBY_REQUEST_PIN) begin
            err_latch_ff <= 1'b0;
         end else if (ev[`MDMS_IRQ_ERROR]) begin
            err_latch_ff <= 1'b1;
         end
         case (nxt_state)
            ST_LOAD: mode_out <= 3'h0;
            ST_BRAKE: mode_out <= 3'h1;
            ST_HOLD: mode_out <= 3'h1;
            ST_IDLE: mode_out <= 3'h2;
            ST_START: mode_out <= 3'h3;
            ST_RUN: mode_out <= 3'h4;
            ST_ERROR: mode_out <= 3'h5;
            ST_STANDBY_REQUEST_PIN: mode_out <= 3'h6;
            default: mode_out <= 3'h0;
         endcase
         drive_enable <= (nxt_state == ST_START) || (nxt_state == ST_RUN);
         // brake style picks short brake or all-off while braking or holding
         short_brake <= (nxt_state == ST_BRAKE || nxt_state == ST_HOLD) &&
            cfg_ff[`MDMS_CFG_BRAKE_STYLE];
         fets_hiz <= !((nxt_state == ST_START) || (nxt_state == ST_RUN) ||
            ((nxt_state == ST_BRAKE || nxt_state == ST_HOLD) &&
            cfg_ff[`MDMS_CFG_BRAKE_STYLE]));
      end
   end

   // registers; cfg is reloaded from the stored image during the load state
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff <= `MDMS_CFG_RESET;
         ctrl_ff <= `MDMS_CTRL_RESET;
         restart_ff <= `MDMS_RESTART_RESET;
         irq_mask_ff <= 4'h0;
         irq_stat_ff <= 4'h0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
      end else begin
         // answer and read data are prepared in setup so they stand with pready
         pready <= apb_setup;
         pslverr <= apb_setup && !apb_hit;
         if (state_ff == ST_LOAD) begin
            cfg_ff <= nvm_s2_ff;
         end
         if (apb_wr && pready) begin
            case (paddr)
               `MDMS_ADDR_CTRL: ctrl_ff <= pwdata[7:0];
               `MDMS_ADDR_CFG: begin
                  if (state_ff != ST_LOAD) begin
                     cfg_ff <= pwdata[10:0];
                  end
               end
               `MDMS_ADDR_RESTART: restart_ff <= pwdata[15:0];
               `MDMS_ADDR_IRQ_MASK: irq_mask_ff <= pwdata[3:0];
               `MDMS_ADDR_STATUS: ;
               `MDMS_ADDR_IRQ_STAT: ;
               default: ;
            endcase
         end
         if (apb_setup && !pwrite) begin
            case (paddr)
               `MDMS_ADDR_CTRL: prdata <= {24'h000000, ctrl_ff};
               `MDMS_ADDR_CFG: prdata <= {21'h000000, cfg_ff};
               `MDMS_ADDR_RESTART: prdata <= {16'h0000, restart_ff};
               `MDMS_ADDR_STATUS: prdata <= {18'h00000, standby_request_pin_pin, err_latch_ff, fault,
                  mode_out, state_ff};
               `MDMS_ADDR_IRQ_STAT: prdata <= {28'h0000000, irq_stat_ff};
               `MDMS_ADDR_IRQ_MASK: prdata <= {28'h0000000, irq_mask_ff};
               default: prdata <= 32'h00000000;
            endcase
         end
         // read clears, but a new event in the same cycle survives
         irq_stat_ff <= nxt_irq_stat;
         irq <= |(nxt_irq_stat & irq_mask_ff);
      end
   end
endmodule

// *** mdms_sequencer_bench.sv ***
// self-checking bench for the mode sequencer with a bridge model
// assumes short counts: 50 cycle standby hold, 20 cycle second
`timescale 1ns/10ps
`include "mdms_map.vh"
module mdms_sequencer_bench;
   reg clock = 1'b0;
   reg rst_n = 1'b0;
   reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trip = 1'b0, err;
   reg standby_request_pin = 1'b1;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0, q;
   reg [10:0] nvm_cfg = 11'h011;
   wire [31:0] prdata;
   wire pready, pslverr, fault_in, drive_enable, short_brake, fets_hiz, irq;
   wire [2:0] mode_out;
   integer num_errors = 0, n_tests = 0, k;
   always #50 clock = ~clock;
   mdms_sequencer #(.STANDBY_REQUEST_PIN_CYC(50), .SEC_CYC(20), .RESTART_UNIT(2)) u_dut (.clock(clock),
      .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nvm_cfg(nvm_cfg), .standby_request_pin(standby_request_pin), .fault_in(fault_in),
      .mode_out(mode_out), .drive_enable(drive_enable), .short_brake(short_brake),
      .fets_hiz(fets_hiz), .irq(irq));
   mdms_bridge_model u_bridge (.drive_enable(drive_enable), .short_brake(short_brake),
      .fets_hiz(fets_hiz), .trip(trip), .fault_out(fault_in), .bridge_state());
   task report_and_stop;
      begin
         if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task apb(input [11:0] a, input w, input [31:0] d);
      integer i;
      begin
         @(posedge clock);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         penable <= 1'b0;
         @(posedge clock);
         penable <= 1'b1;
         i = 0;
         @(posedge clock);
         while (pready !== 1'b1 && i < 20) begin
            @(posedge clock);
            i = i + 1;
         end
         if (i >= 20) begin
            num_errors = num_errors + 1;
            report_and_stop;
         end
         q = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wait_mode(input [2:0] m);
      integer i;
      begin
         i = 0;
         @(negedge clock);
         while (mode_out !== m && i < 400) begin
            @(negedge clock);
            i = i + 1;
         end
         chk({29'h0, mode_out}, {29'h0, m});
         if (i >= 400)
            report_and_stop;
      end
   endtask
   task t_power_on;
      begin
         wait_mode(3'h1);
         chk({31'h0, short_brake}, 32'h1);
         wait_mode(3'h2);
         apb(`MDMS_ADDR_CFG, 1'b0, 32'h0);
         chk(q, 32'h011);
         apb(12'h020, 1'b0, 32'h0);
         chk({31'h0, err}, 32'h1);
      end
   endtask
   task t_error;
      begin
         apb(`MDMS_ADDR_IRQ_MASK, 1'b1, 32'h1);
         apb(`MDMS_ADDR_CTRL, 1'b1, 32'h5);
         wait_mode(3'h4);
         trip <= 1'b1;
         wait_mode(3'h5);
         chk({31'h0, irq}, 32'h1);
         trip <= 1'b0;
         wait_mode(3'h4);
         trip <= 1'b1;
         wait_mode(3'h5);
         apb(`MDMS_ADDR_CTRL, 1'b1, 32'h0);
         wait_mode(3'h2);
         trip <= 1'b0;
         apb(`MDMS_ADDR_IRQ_STAT, 1'b0, 32'h0);
         chk({31'h0, q[0]}, 32'h1);
         @(negedge clock);
         chk({31'h0, irq}, 32'h0);
      end
   endtask
   task t_standby;
      begin
         standby_request_pin <= 1'b0;
         repeat (30) @(posedge clock);
         standby_request_pin <= 1'b1;
         repeat (5) @(negedge clock);
         chk({29'h0, mode_out}, 32'h2);
         standby_request_pin <= 1'b0;
         wait_mode(3'h6);
         chk({31'h0, short_brake}, 32'h0);
         apb(`MDMS_ADDR_STATUS, 1'b0, 32'h0);
         chk({29'h0, q[12], q[9:8]}, 32'h2);
         nvm_cfg <= 11'h019;
         standby_request_pin <= 1'b1;
         wait_mode(3'h1);
         repeat (40) @(negedge clock);
         chk({30'h0, mode_out[1:0], short_brake}, 32'h3);
         apb(`MDMS_ADDR_CTRL, 1'b1, 32'h3);
         wait_mode(3'h3);
      end
   endtask
   task t_sel1;
      begin
         apb(`MDMS_ADDR_CFG, 1'b1, 32'h080);
         standby_request_pin <= 1'b0;
         repeat (70) @(negedge clock);
         chk({29'h0, mode_out}, 32'h4);
         apb(`MDMS_ADDR_CTRL, 1'b1, 32'h0);
         for (k = 8; k < 11; k = k + 1) begin
            apb(`MDMS_ADDR_CFG, 1'b1, 32'h080 | (32'h1 << k));
            repeat (70) @(negedge clock);
            chk({29'h0, mode_out}, 32'h2);
         end
         apb(`MDMS_ADDR_CFG, 1'b1, 32'h080);
         wait_mode(3'h6);
      end
   endtask
   initial begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      t_power_on;
      t_error;
      t_standby;
      t_sel1;
      report_and_stop;
   end
endmodule
